// *** rtl/ddrs_ctrl.sv ***
/*
 * Command, burst, bank-select, echo-clock and impedance-update control of a
 * DDR synchronous SRAM, with array requests queued through ddrs_fifo.
 * Assumes the link clock is much slower than sys_clk (at least 16 sys_clk
 * per link cycle) and that the array side answers reads in order.
 */
`timescale 1ns/1ps
`include "ddrs_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R01: hidden low array bit is 0 on the first transfer, 1 on the second.
// R02: one continue after read or write moves four words per base address.
// R03: a second continue wraps the burst back to the base address.
// R04: second pair address inverts address bit one of the base.
// R05: first programmable select is active high or low per its polarity input.
// R06: second programmable select is active high or low per its polarity input.
// R07: bank matches only when both selects equal their polarity inputs.
// R08: system straps four banks 00..11 and drives selects from address lines.
// R09: deselect by the primary select keeps echo clocks toggling.
// R10: deselect by bank mismatch puts echo clocks into high impedance.
// R11: impedance updates are applied only while data drivers are off.
// R12: controller gives 8192 clocks then an idling command after power-up.
// R13: controller idles data drivers periodically so impedance can track drift.
// R14: data pins float one cycle after bank deselect, deselect or write.
// R15: continue inverts address bit one of the base for the next pair.
// R16: echo clocks float one cycle after bank deselect only.
// R17: all command and address inputs are sampled on the link clock rise.
module ddrs_ctrl
  import ddrs_pkg::*;
#(
  parameter int EXT_ADDR_W  = `DDRS_EXT_ADDR_W,
  parameter int DATA_W      = `DDRS_DATA_W,
  parameter int FIFO_DEPTH  = `DDRS_FIFO_DEPTH,
  parameter int SETTLE_CYC  = `DDRS_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // Link command pins
  input  wire logic                  link_clk,
  input  wire logic                  primary_select_n,
  input  wire logic                  prog_select_a,
  input  wire logic                  prog_select_b,
  input  wire logic                  polarity_a,
  input  wire logic                  polarity_b,
  input  wire logic                  burst_continue,
  input  wire logic                  write_n,
  input  wire logic [EXT_ADDR_W-1:0] ext_addr,
  // Link data and echo clock pins
  input  wire logic [DATA_W-1:0]     dq_in,
  output logic [DATA_W-1:0]          dq_out,
  output logic                       dq_oe,
  output logic                       echo_clock_out,
  output logic                       echo_clock_oe,
  // Impedance control
  input  wire logic [`DDRS_ZQ_W-1:0] zq_code,
  output logic [`DDRS_ZQ_W-1:0]      imp_code,
  output logic                       imp_settled,
  // Array side
  output logic                       req_valid,
  input  wire logic                  req_ready,
  output ddrs_req_t                  req,
  input  wire logic                  rd_valid,
  input  wire logic [DATA_W-1:0]     rd_data,
  // Status
  output logic                       cmd_ready,
  output logic                       overrun
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  if (EXT_ADDR_W != `DDRS_EXT_ADDR_W || DATA_W != `DDRS_DATA_W || EXT_ADDR_W < 2
      || SETTLE_CYC < 1) begin : g_bad_param
    $error("ddrs_ctrl: widths must match the shared request type");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; first stage read only by second
  ddrs_pins_t pins_meta;
  ddrs_pins_t pins;
  logic       clk_prev;
  logic       rise;
  logic       fall;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins_meta <= '0;
      pins      <= '0;
      clk_prev  <= 1'b0;
    end else if (ce) begin
      pins_meta <= '{link_clk, primary_select_n, prog_select_a, prog_select_b,
                     polarity_a, polarity_b, burst_continue, write_n, ext_addr, dq_in};
      pins      <= pins_meta;
      clk_prev  <= pins.link_clk;
    end
  end

  assign rise = ce && pins.link_clk && !clk_prev;
  assign fall = ce && !pins.link_clk && clk_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  ddrs_op_t              op;
  ddrs_op_t              next_op;
  logic                  bank_match;
  logic                  cont_burst;
  logic [EXT_ADDR_W-1:0] base;
  logic [EXT_ADDR_W-1:0] next_base;
  logic                  flip;
  logic                  next_flip;
  logic [EXT_ADDR_W-1:0] cur_hi;
  logic [EXT_ADDR_W-1:0] next_hi;
  logic [1:0]            cont_cnt;

  // R05 R06 R07: polarity-matched bank select
  assign bank_match = (pins.prog_select_a == pins.polarity_a)
                   && (pins.prog_select_b == pins.polarity_b);
  assign cont_burst = pins.burst_continue && (op == OP_READ || op == OP_WRITE);

  // R04 R15: pair address is base with bit one inverted
  assign cur_hi  = {base[EXT_ADDR_W-1:1], base[0] ^ flip};
  assign next_hi = {next_base[EXT_ADDR_W-1:1], next_base[0] ^ next_flip};

  always_comb begin
    next_op   = op;
    next_base = base;
    next_flip = flip;
    if (pins.burst_continue) begin
      // R02 R03: continue toggles the pair, second one wraps to base
      next_flip = cont_burst ? ~flip : flip;
    end else if (!bank_match) begin
      next_op = OP_BANK_OFF;
    end else if (pins.primary_select_n) begin
      next_op = OP_DESEL;
    end else begin
      next_op   = pins.write_n ? OP_READ : OP_WRITE;
      next_base = pins.addr;
      next_flip = 1'b0;
    end
  end

  // R17: state moves only on a sampled link clock rise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op       <= OP_DESEL;
      base     <= '0;
      flip     <= 1'b0;
      cont_cnt <= 2'h0;
    end else if (rise) begin
      op       <= next_op;
      base     <= next_base;
      flip     <= next_flip;
      cont_cnt <= cont_burst ? cont_cnt + 2'h1 : (pins.burst_continue ? cont_cnt : 2'h0);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output enables, echo clock, read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_oe         <= 1'b0;
      echo_clock_oe <= 1'b0;
    end else if (rise) begin
      // R14: drivers follow the command one cycle later
      dq_oe         <= (op == OP_READ);
      // R09 R10 R16: only bank deselect floats the echo clocks
      echo_clock_oe <= (op != OP_BANK_OFF);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      echo_clock_out <= 1'b0;
      dq_out         <= '0;
    end else if (ce) begin
      echo_clock_out <= pins.link_clk;
      if (rd_valid) begin
        dq_out <= rd_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array requests: write beats at rise and fall, reads in two steps
  logic                  wr2_pend;
  logic [EXT_ADDR_W-1:0] wr_hi;
  logic [1:0]            rd_step;
  logic [EXT_ADDR_W-1:0] rd_hi;
  logic                  push_valid;
  ddrs_req_t             push_req;
  logic                  fifo_in_ready;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr2_pend <= 1'b0;
      wr_hi    <= '0;
      rd_step  <= 2'h0;
      rd_hi    <= '0;
    end else if (ce) begin
      if (rise && op == OP_WRITE) begin
        wr2_pend <= 1'b1;
        wr_hi    <= cur_hi;
      end else if (fall) begin
        wr2_pend <= 1'b0;
      end
      if (rise && next_op == OP_READ) begin
        rd_step <= 2'h1;
        rd_hi   <= next_hi;
      end else if (rd_step != 2'h0) begin
        rd_step <= (rd_step == 2'h2) ? 2'h0 : 2'h2;
      end
    end
  end

  // R01: first transfer uses low bit 0, second uses 1
  always_comb begin
    push_valid = 1'b0;
    push_req   = '0;
    if (rise && op == OP_WRITE) begin
      push_valid = 1'b1;
      push_req   = '{1'b1, {cur_hi, `DDRS_LSB_FIRST}, pins.dq};
    end else if (fall && wr2_pend) begin
      push_valid = 1'b1;
      push_req   = '{1'b1, {wr_hi, `DDRS_LSB_SECOND}, pins.dq};
    end else if (rd_step == 2'h1) begin
      push_valid = 1'b1;
      push_req   = '{1'b0, {rd_hi, `DDRS_LSB_FIRST}, {DATA_W{1'b0}}};
    end else if (rd_step == 2'h2) begin
      push_valid = 1'b1;
      push_req   = '{1'b0, {rd_hi, `DDRS_LSB_SECOND}, {DATA_W{1'b0}}};
    end
  end

  assign cmd_ready = fifo_in_ready;

  // The link cannot be stalled, so a full queue loses the access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overrun <= 1'b0;
    end else if (ce && push_valid && !fifo_in_ready) begin
      overrun <= 1'b1;
    end
  end

  ddrs_fifo #(
    .WIDTH ($bits(ddrs_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_req),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (req)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Impedance update and power-up settling
  logic [CW-1:0] settle_cnt;

  // R11: new code taken only while data drivers are off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      imp_code <= `DDRS_IMP_RESET;
    end else if (ce && !dq_oe) begin
      imp_code <= zq_code;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settle_cnt  <= '0;
      imp_settled <= 1'b0;
    end else if (rise) begin
      if (settle_cnt != SETTLE_CYC[CW-1:0]) begin
        settle_cnt <= settle_cnt + 1'b1;
      end else if (next_op != OP_READ) begin
        imp_settled <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_read_first;
    rd_step == 2'h1 && push_req.addr[0] == `DDRS_LSB_FIRST;
  endsequence
  sequence s_read_second;
    rd_step == 2'h2 && push_req.addr[0] == `DDRS_LSB_SECOND;
  endsequence

  a_read_lsb_order: assert property ( // R01
    @(posedge sys_clk) disable iff (rst)
    (rd_step == 2'h1 && ce && !rise && !fall) |-> s_read_first ##1 s_read_second)
    else $error("read pair not issued low bit 0 then 1");
  // Odd count before this continue means the pair returns to the base
  a_burst_wrap: assert property ( // R03
    @(posedge sys_clk) disable iff (rst)
    (rise && cont_burst && cont_cnt[0]) |=> (cur_hi == base))
    else $error("burst address did not wrap after second continue");
  a_pair_flip: assert property ( // R04
    @(posedge sys_clk) disable iff (rst)
    (rise && cont_burst) |=> (flip != $past(flip) && base == $past(base)))
    else $error("continue did not invert address bit one");
  a_bank_mismatch: assert property ( // R07
    @(posedge sys_clk) disable iff (rst)
    (rise && !pins.burst_continue && !bank_match) |=> op == OP_BANK_OFF)
    else $error("mismatched bank select did not deselect bank");
  a_polarity_match: assert property ( // R05 R06
    @(posedge sys_clk) disable iff (rst)
    (rise && !pins.burst_continue && !pins.primary_select_n
     && pins.prog_select_a == pins.polarity_a && pins.prog_select_b == pins.polarity_b)
    |=> (op == OP_READ || op == OP_WRITE))
    else $error("polarity-matched selects did not start an access");
  a_echo_keep: assert property ( // R09
    @(posedge sys_clk) disable iff (rst)
    (rise && op == OP_DESEL) |=> echo_clock_oe)
    else $error("echo clock floated on primary deselect");
  a_echo_float: assert property ( // R10 R16
    @(posedge sys_clk) disable iff (rst)
    (rise && op == OP_BANK_OFF) |=> !echo_clock_oe ##1 !echo_clock_oe)
    else $error("echo clock not floated after bank deselect");
  a_dq_float: assert property ( // R14
    @(posedge sys_clk) disable iff (rst)
    (rise && op != OP_READ) |=> !dq_oe)
    else $error("data pins driven after non-read command");
  a_imp_hold: assert property ( // R11
    @(posedge sys_clk) disable iff (rst)
    (dq_oe && $past(dq_oe)) |-> $stable(imp_code))
    else $error("impedance changed while data drivers active");
  a_cmd_on_rise: assert property ( // R17
    @(posedge sys_clk) disable iff (rst)
    !rise |=> ($stable(op) && $stable(base)))
    else $error("command state changed without link clock rise");

endmodule : ddrs_ctrl

// *** pkg/ddrs_consts.svh ***
/*
 * Constants of the DDR SRAM burst and bank-select control block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef DDRS_CONSTS_SVH
`define DDRS_CONSTS_SVH

// External address width; the hidden low array bit is added inside
`define DDRS_EXT_ADDR_W   17
`define DDRS_DATA_W       18
`define DDRS_ZQ_W         6
`define DDRS_FIFO_DEPTH   8
// Link clock cycles before the impedance counts as settled
`define DDRS_SETTLE_CYC   8192
// Hidden low address bit for the first and second transfer
`define DDRS_LSB_FIRST    1'h0
`define DDRS_LSB_SECOND   1'h1
`define DDRS_IMP_RESET    6'h00

`endif

// *** pkg/ddrs_pkg.sv ***
/*
 * Types shared by the DDR SRAM control block and its request FIFO.
 * Assumes ddrs_consts.svh on the include path.
 */
`include "ddrs_consts.svh"

package ddrs_pkg;

  // Operation in force after the last sampled link clock rise
  typedef enum logic [1:0] {
    OP_BANK_OFF,
    OP_DESEL,
    OP_READ,
    OP_WRITE
  } ddrs_op_t;

  // One array access, hidden low bit included in addr
  typedef struct packed {
    logic                      write;
    logic [`DDRS_EXT_ADDR_W:0] addr;
    logic [`DDRS_DATA_W-1:0]   data;
  } ddrs_req_t;

  // Link pins as sampled by sys_clk
  typedef struct packed {
    logic                        link_clk;
    logic                        primary_select_n;
    logic                        prog_select_a;
    logic                        prog_select_b;
    logic                        polarity_a;
    logic                        polarity_b;
    logic                        burst_continue;
    logic                        write_n;
    logic [`DDRS_EXT_ADDR_W-1:0] addr;
    logic [`DDRS_DATA_W-1:0]     dq;
  } ddrs_pins_t;

endpackage : ddrs_pkg

// *** rtl/ddrs_fifo.sv ***
/*
 * Request FIFO with registered read data and valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps
`include "ddrs_consts.svh"

module ddrs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = `DDRS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("ddrs_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != DEPTH[PW:0]);
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Head word is registered; bypass when the head is written this cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_data <= '0;
    end else if (ce) begin
      if (push && wr_ptr == next_rd_ptr) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[next_rd_ptr];
      end
    end
  end

endmodule : ddrs_fifo

// *** test/ddrs_mc_model.sv ***
/*
 * Behavioural memory controller that drives the SRAM command and data pins.
 * Assumes sys_clk from the bench; the bench calls cmd() once per link cycle.
 */
`timescale 1ns/1ps

module ddrs_mc_model (
  // System clock
  input  wire logic   sys_clk,
  // Link command pins
  output logic        link_clk,
  output logic        primary_select_n,
  output logic        prog_select_a,
  output logic        prog_select_b,
  output logic        burst_continue,
  output logic        write_n,
  output logic [16:0] ext_addr,
  output logic [17:0] dq
);

  ////////////////////////////////////////////////////////////////////////////
  // Free running: impedance settling needs a steady clock
  initial begin
    link_clk = 1'h0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  initial begin
    {primary_select_n, prog_select_a, prog_select_b} = 3'h4;
    burst_continue = 1'h0;
    write_n        = 1'h1;
    ext_addr       = 17'h00000;
    dq             = 18'h00000;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // set mid low phase, held across rise
  task automatic cmd(input logic sn, input logic [1:0] sel, input logic cont,
                     input logic wn, input logic [16:0] a, input logic [17:0] d1,
                     input logic [17:0] d2);
    @(negedge link_clk);
    tick(4);
    primary_select_n <= sn;
    {prog_select_a, prog_select_b} <= sel;
    burst_continue <= cont;
    write_n <= wn;
    ext_addr <= a;
    // first beat for the rise, second for the fall
    dq <= d1;
    @(posedge link_clk);
    tick(4);
    dq <= d2;
    tick(2);
    #1;
  endtask : cmd

endmodule : ddrs_mc_model

// *** test/tb_ddrs_ctrl.sv ***
/*
 * Self-checking bench for ddrs_ctrl: bursts, writes, bank matching, echo
 * clock, impedance update and request FIFO. Assumes ddrs_pkg is compiled.
 */
`timescale 1ns/1ps

module tb_ddrs_ctrl
  import ddrs_pkg::*;
;
  localparam logic [16:0] BASE = 17'h0a5a4;

  logic        sys_clk    = 1'h0;
  logic        rst        = 1'h1;
  logic        ce         = 1'h1;
  logic        polarity_a = 1'h1;
  logic        polarity_b = 1'h0;
  logic [5:0]  zq_code    = 6'h15;
  logic        req_ready  = 1'h1;
  logic        rd_valid   = 1'h0;
  logic [17:0] rd_data    = 18'h00000;
  logic        link_clk, primary_select_n, prog_select_a, prog_select_b;
  logic        burst_continue, write_n, dq_oe, echo_clock_out, echo_clock_oe;
  logic        imp_settled, req_valid, cmd_ready, overrun, e0;
  logic [16:0] ext_addr;
  logic [17:0] dq_in, dq_out;
  logic [5:0]  imp_code;
  ddrs_req_t   req;
  ddrs_req_t   got[$];
  int          n_mismatch = 0;
  int          n_tests    = 0;

  always #5 sys_clk = ~sys_clk;

  ddrs_mc_model ddrs_mc_model_inst (
    .sys_clk, .link_clk, .primary_select_n, .prog_select_a, .prog_select_b,
    .burst_continue, .write_n, .ext_addr, .dq(dq_in)
  );

  ddrs_ctrl #(.SETTLE_CYC(16)) ddrs_ctrl_inst (
    .sys_clk, .rst, .ce, .link_clk, .primary_select_n, .prog_select_a, .prog_select_b,
    .polarity_a, .polarity_b, .burst_continue, .write_n, .ext_addr, .dq_in, .dq_out,
    .dq_oe, .echo_clock_out, .echo_clock_oe, .zq_code, .imp_code, .imp_settled,
    .req_valid, .req_ready, .req, .rd_valid, .rd_data, .cmd_ready, .overrun
  );

  // Array side: log every accepted request
  always @(posedge sys_clk)
    if (req_valid === 1'h1 && req_ready === 1'h1) got.push_back(req);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'h1) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic op(input logic sn, input logic cont, input logic wn,
                    input logic [16:0] a, input logic [17:0] d1, input logic [17:0] d2);
    ddrs_mc_model_inst.cmd(sn, {polarity_a, polarity_b}, cont, wn, a, d1, d2);
  endtask : op

  task automatic rd(input logic [16:0] a);
    op(1'h0, 1'h0, 1'h1, a, 18'h2aaaa, 18'h15555);
  endtask : rd

  task automatic ds();
    op(1'h1, 1'h0, 1'h1, 17'h1ffff, 18'h15555, 18'h2aaaa);
  endtask : ds

  task automatic ct();
    op(1'h0, 1'h1, 1'h1, 17'h00000, 18'h2aaaa, 18'h15555);
  endtask : ct

  task automatic chk_rd(input int i, input logic [16:0] a, input logic lsb);
    chk(got.size() > i && got[i].write === 1'h0 && got[i].addr === {a, lsb},
        "read request address");
  endtask : chk_rd

  ////////////////////////////////////////////////////////////////////////////
  // Roughly 53 link commands of one link cycle each, with wide margin
  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(dq_oe === 1'h0 && echo_clock_oe === 1'h0 && req_valid === 1'h0, "reset enables");
    chk(cmd_ready === 1'h1 && overrun === 1'h0 && imp_settled === 1'h0, "reset status");
    chk(imp_code === 6'h15, "impedance tracks when idle");
    // Read, continue, continue wraps to base
    got = {};
    rd(BASE);
    ct();
    chk(dq_oe === 1'h1 && echo_clock_oe === 1'h1, "read drives data");
    @(posedge sys_clk);
    zq_code <= 6'h2a;
    // Must return before the next link fall, or the held continue repeats
    @(posedge sys_clk);
    #1;
    chk(imp_code === 6'h15, "impedance held while driving");
    ct();
    ds();
    ds();
    chk(dq_oe === 1'h0, "deselect floats data");
    chk(imp_code === 6'h2a, "impedance updated when idle");
    chk(got.size() == 6, "burst moves six words");
    for (int i = 0; i < 6; i++) begin
      chk_rd(i, (i / 2 == 1) ? BASE ^ 17'h00001 : BASE, i[0]);
    end
    // Write with both beats
    got = {};
    op(1'h0, 1'h0, 1'h0, 17'h13579, 18'h0f0f0, 18'h30c3c);
    op(1'h1, 1'h0, 1'h1, 17'h00000, 18'h12345, 18'h2bcde);
    chk(dq_oe === 1'h0 && echo_clock_oe === 1'h1, "write floats data only");
    ds();
    chk(got.size() == 2, "write moves two words");
    chk(got[0] === {1'h1, 17'h13579, 1'h0, 18'h12345}, "write first beat");
    chk(got[1] === {1'h1, 17'h13579, 1'h1, 18'h2bcde}, "write second beat");
    // Write continue: second pair on base with bit one inverted
    got = {};
    op(1'h0, 1'h0, 1'h0, 17'h13579, 18'h0f0f0, 18'h30c3c);
    ct();
    ds();
    ds();
    chk(got.size() == 4, "write burst moves four words");
    chk(got[0] === {1'h1, 17'h13579, 1'h0, 18'h2aaaa}, "write burst first beat");
    chk(got[2] === {1'h1, 17'h13578, 1'h0, 18'h15555}, "write burst second pair");
    chk(got[3] === {1'h1, 17'h13578, 1'h1, 18'h2aaaa}, "write burst last beat");
    // Every strap code against every select code
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge sys_clk);
        {polarity_a, polarity_b} <= 2'(p);
        got = {};
        ddrs_mc_model_inst.cmd(1'h0, 2'(s), 1'h0, 1'h1, 17'h00100, 18'h0, 18'h3ffff);
        ds();
        chk(echo_clock_oe === (s == p), "echo enable follows bank match");
        chk(got.size() == ((s == p) ? 2 : 0), "access only on bank match");
      end
    end
    ds();
    ds();
    e0 = echo_clock_out;
    repeat (8) @(posedge sys_clk);
    #1;
    chk(echo_clock_oe === 1'h1 && echo_clock_out !== e0, "echo toggles deselected");
    // Fill the FIFO with the array stalled, then drain
    @(posedge sys_clk);
    req_ready <= 1'h0;
    got = {};
    for (int i = 0; i < 4; i++) begin
      rd(17'h00200 + 17'(4 * i));
    end
    chk(cmd_ready === 1'h0 && overrun === 1'h0, "full after eight words");
    rd(17'h00210);
    chk(overrun === 1'h1, "push into full FIFO flagged");
    ds();
    @(posedge sys_clk);
    req_ready <= 1'h1;
    repeat (20) @(posedge sys_clk);
    #1;
    chk(got.size() == 8 && cmd_ready === 1'h1 && req_valid === 1'h0, "FIFO drained");
    chk_rd(0, 17'h00200, 1'h0);
    chk_rd(7, 17'h0020c, 1'h1);
    // Read data return
    @(posedge sys_clk);
    rd_valid <= 1'h1;
    rd_data <= 18'h2b3c1;
    @(posedge sys_clk);
    rd_valid <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk(dq_out === 18'h2b3c1, "read data to pins");
    // Clock enable low must swallow a data return
    @(posedge sys_clk);
    ce <= 1'h0;
    rd_valid <= 1'h1;
    rd_data <= 18'h0c3a5;
    @(posedge sys_clk);
    rd_valid <= 1'h0;
    ce <= 1'h1;
    @(posedge sys_clk);
    #1;
    chk(dq_out === 18'h2b3c1, "clock enable low freezes data");
    ds();
    chk(imp_settled === 1'h1, "impedance settled after idling");
    complete_run();
  end

endmodule : tb_ddrs_ctrl
